/* ibsf_map.svh */
`ifndef IBSF_MAP_SVH
`define IBSF_MAP_SVH
// register offsets on the cpu bus
`define IBSF_STATUS_OFF 16'hffaa
`define IBSF_CONTROL_OFF 16'hffa6
// bus_control_reg bit positions
`define IBSF_CTL_EN 7
`define IBSF_CTL_EXIT 6
`define IBSF_CTL_WREL 5
`define IBSF_CTL_STT 1
`define IBSF_CTL_SPT 0
// reset value of bus_status_reg
`define IBSF_STATUS_RST 8'h00
// bit counter marks within a byte
`define IBSF_CNT_ZERO 4'h0
`define IBSF_CNT_ONE 4'h1
`define IBSF_CNT_RW 4'h7
`define IBSF_CNT_ACK 4'h8
`define IBSF_CNT_NINTH 4'h9
// extension code patterns in the upper address nibble
`define IBSF_EXT_LO 4'h0
`define IBSF_EXT_HI 4'hf
`endif

/* ibsf_pkg.sv */
package ibsf_pkg;
   // bus_status_reg layout, bit 7 down to bit 0
   typedef struct packed {
      logic master_active_flag;
      logic arb_lost_flag;
      logic ext_code_flag;
      logic addr_match_flag;
      logic transmit_state_flag;
      logic ack_seen_flag;
      logic start_seen_flag;
      logic stop_seen_flag;
   } ibsf_status_s;

   // cpu access request
   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } ibsf_cpu_req_s;

   // whole state of the block
   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic scl_p;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      logic [3:0] cnt;
      logic [6:0] shift;
      logic first_byte;
      logic wait_hold;
      logic drive;
      logic enable;
      logic start_request;
      logic stop_pulse;
      logic rd_pend;
      logic [7:0] rdata;
      ibsf_status_s stat;
   } ibsf_state_s;
endpackage : ibsf_pkg

/* ibsf_status.sv */
`timescale 1ns/100ps
`include "ibsf_map.svh"

// What this block does
// - wait release in ninth clock drops transmit
// - stop request reads back zero
// - reset forces status register to zero
// - each status read inserts one wait
// - master flag set on own start
// - master flag clears on stop, loss, exit, disable
// - arbitration loss sets flag, clears master
// - arbitration flag clears on read or disable
// - only a status read or disable clears arbitration flag; a status write leaves it
// - extension flag on eighth clock, nibble 0000/1111
// - extension flag clears on start, stop, exit, disable
// - exit is control bit 6, enable bit 7
// - address match flag set on eighth clock
// - transmit flag gates latch onto data line
module ibsf_status (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // cpu register access
   input wire ibsf_pkg::ibsf_cpu_req_s cpu_req_i,
   output logic [7:0] cpu_rdata_o,
   output logic cpu_wait_o,
   // slave address and shift path
   input wire logic [6:0] own_slave_addr_i,
   input wire logic shift_out_latch_i,
   // control towards the condition generators
   output logic controller_enable_o,
   output logic start_request_o,
   output logic stop_request_o,
   // serial clock pin
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   // serial data pin
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o
);

   // ==========================================================
   // address decode
   function automatic logic ibsf_hit(input logic [15:0] addr, input logic [15:0] off);
      ibsf_hit = (addr == off);
   endfunction : ibsf_hit

   ibsf_pkg::ibsf_state_s s_q;
   ibsf_pkg::ibsf_state_s s_d;
   logic rd_stat;
   logic rd_done;
   logic wr_ctl;
   logic en_fall;
   logic comm_exit_request;
   logic wait_release;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic eighth;
   logic ninth;
   logic arb_loss;
   logic [3:0] upper;

   // ==========================================================
   // cpu side decode
   always_comb begin
      rd_stat = cpu_req_i.rd & ibsf_hit(cpu_req_i.addr, `IBSF_STATUS_OFF);
      rd_done = rd_stat & s_q.rd_pend;
      wr_ctl = cpu_req_i.wr & ibsf_hit(cpu_req_i.addr, `IBSF_CONTROL_OFF);
      en_fall = wr_ctl & s_q.enable & ~cpu_req_i.wdata[`IBSF_CTL_EN];
      comm_exit_request = wr_ctl & cpu_req_i.wdata[`IBSF_CTL_EXIT];
      wait_release = wr_ctl & cpu_req_i.wdata[`IBSF_CTL_WREL];
   end

   // ==========================================================
   // link events from synchronised pins
   always_comb begin
      scl_rise = s_q.enable & s_q.scl_s & ~s_q.scl_p;
      scl_fall = s_q.enable & ~s_q.scl_s & s_q.scl_p;
      start_det = s_q.enable & s_q.scl_s & s_q.scl_p & ~s_q.sda_s & s_q.sda_p;
      stop_det = s_q.enable & s_q.scl_s & s_q.scl_p & s_q.sda_s & ~s_q.sda_p;
      eighth = scl_rise & s_q.first_byte & (s_q.cnt == `IBSF_CNT_RW);
      ninth = scl_rise & (s_q.cnt == `IBSF_CNT_ACK);
      upper = s_q.shift[6:3];
      // we released a one but the line reads low; the ack slot is the receiver's
      arb_loss = scl_rise & s_q.stat.master_active_flag & (s_q.cnt != `IBSF_CNT_ACK)
         & s_q.stat.transmit_state_flag & shift_out_latch_i & ~s_q.sda_s;
   end

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.scl_m = scl_i;
      s_d.scl_s = s_q.scl_m;
      s_d.scl_p = s_q.scl_s;
      s_d.sda_m = sda_i;
      s_d.sda_s = s_q.sda_m;
      s_d.sda_p = s_q.sda_s;
      s_d.stop_pulse = 1'b0;
      // control register writes
      if (wr_ctl) begin
         s_d.enable = cpu_req_i.wdata[`IBSF_CTL_EN];
         if (cpu_req_i.wdata[`IBSF_CTL_STT]) begin
            s_d.start_request = 1'b1;
         end
         s_d.stop_pulse = cpu_req_i.wdata[`IBSF_CTL_SPT];
      end
      // status read: one wait cycle, then data
      s_d.rd_pend = rd_stat & ~s_q.rd_pend;
      if (cpu_req_i.rd) begin
         if (ibsf_hit(cpu_req_i.addr, `IBSF_STATUS_OFF)) begin
            s_d.rdata = s_q.stat;
         end else if (ibsf_hit(cpu_req_i.addr, `IBSF_CONTROL_OFF)) begin
            s_d.rdata = 8'h00;
            s_d.rdata[`IBSF_CTL_EN] = s_q.enable;
            s_d.rdata[`IBSF_CTL_STT] = s_q.start_request;
         end else begin
            s_d.rdata = 8'h00;
         end
      end
      // bit counter and address shifter
      if (scl_rise && s_q.cnt != `IBSF_CNT_NINTH) begin
         s_d.cnt = s_q.cnt + `IBSF_CNT_ONE;
         if (s_q.first_byte && s_q.cnt < `IBSF_CNT_RW) begin
            s_d.shift = {s_q.shift[5:0], s_q.sda_s};
         end
      end
      if (scl_fall && s_q.cnt == `IBSF_CNT_NINTH) begin
         s_d.cnt = `IBSF_CNT_ZERO;
         s_d.first_byte = 1'b0;
         s_d.wait_hold = 1'b1;
         s_d.drive = s_q.stat.transmit_state_flag;
      end
      if (wait_release) begin
         s_d.wait_hold = 1'b0;
         if (s_q.stat.transmit_state_flag) begin
            s_d.stat.transmit_state_flag = 1'b0;
            s_d.drive = 1'b0;
         end
      end
      // clears first, so that a simultaneous set wins
      if (rd_done) begin
         s_d.stat.arb_lost_flag = 1'b0;
      end
      if (start_det) begin
         s_d.cnt = `IBSF_CNT_ZERO;
         s_d.first_byte = 1'b1;
         s_d.start_request = 1'b0;
         s_d.stat.ext_code_flag = 1'b0;
         s_d.stat.addr_match_flag = 1'b0;
         s_d.stat.ack_seen_flag = 1'b0;
         s_d.stat.stop_seen_flag = 1'b0;
         s_d.stat.start_seen_flag = 1'b1;
         s_d.stat.transmit_state_flag = s_q.start_request;
         s_d.stat.master_active_flag = s_q.start_request;
      end
      if (stop_det || comm_exit_request) begin
         s_d.wait_hold = 1'b0;
         s_d.drive = 1'b0;
         s_d.first_byte = 1'b0;
         s_d.start_request = 1'b0;
         s_d.stat.master_active_flag = 1'b0;
         s_d.stat.ext_code_flag = 1'b0;
         s_d.stat.addr_match_flag = 1'b0;
         s_d.stat.transmit_state_flag = 1'b0;
         s_d.stat.start_seen_flag = 1'b0;
         s_d.stat.stop_seen_flag = stop_det;
      end
      if (eighth) begin
         if (upper == `IBSF_EXT_LO || upper == `IBSF_EXT_HI) begin
            s_d.stat.ext_code_flag = 1'b1;
         end
         if (s_q.shift == own_slave_addr_i) begin
            s_d.stat.addr_match_flag = 1'b1;
            s_d.stat.transmit_state_flag = s_q.sda_s;
         end
         if (s_q.stat.master_active_flag) begin
            s_d.stat.transmit_state_flag = ~s_q.sda_s;
         end
      end
      if (ninth) begin
         s_d.stat.ack_seen_flag = ~s_q.sda_s;
      end
      if (arb_loss) begin
         s_d.stat.arb_lost_flag = 1'b1;
         s_d.stat.master_active_flag = 1'b0;
         s_d.stat.transmit_state_flag = 1'b0;
         s_d.drive = 1'b0;
      end
      // operation stop clears every flag
      if (en_fall) begin
         s_d.stat = `IBSF_STATUS_RST;
         s_d.wait_hold = 1'b0;
         s_d.drive = 1'b0;
         s_d.start_request = 1'b0;
         s_d.first_byte = 1'b0;
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
         s_q.scl_m <= 1'b1;
         s_q.scl_s <= 1'b1;
         s_q.scl_p <= 1'b1;
         s_q.sda_m <= 1'b1;
         s_q.sda_s <= 1'b1;
         s_q.sda_p <= 1'b1;
         s_q.stat <= `IBSF_STATUS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   assign cpu_rdata_o = s_q.rdata;
   assign cpu_wait_o = rd_stat & ~s_q.rd_pend;
   assign controller_enable_o = s_q.enable;
   assign start_request_o = s_q.start_request;
   assign stop_request_o = s_q.stop_pulse;
   assign scl_o = 1'b0;
   assign scl_oe_n_o = ~s_q.wait_hold; // clock held low in wait
   assign sda_o = 1'b0;
   assign sda_oe_n_o = ~(s_q.drive & s_q.stat.transmit_state_flag & ~shift_out_latch_i);

   // ==========================================================
   // assertions
   default clocking ck @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_status_reset_zero: assert property (
      @(posedge sys_clk_i) disable iff (1'b0) !rst_n_i |=> (s_q.stat == `IBSF_STATUS_RST))
      else $error("status not zero after reset");
   a_stop_reads_zero: assert property (
      cpu_req_i.rd && ibsf_hit(cpu_req_i.addr, `IBSF_CONTROL_OFF) |=> !cpu_rdata_o[0])
      else $error("stop request read back as one");
   a_read_wait_cycle: assert property (
      rd_stat && !s_q.rd_pend |-> cpu_wait_o ##1 (!rd_stat || !cpu_wait_o))
      else $error("status read wait cycle wrong");
   a_master_on_start: assert property (
      start_det && s_q.start_request && !comm_exit_request && !en_fall
         |=> s_q.stat.master_active_flag)
      else $error("master flag not set on own start");
   a_master_clears: assert property (
      stop_det || comm_exit_request || en_fall |=> !s_q.stat.master_active_flag)
      else $error("master flag not cleared");
   a_arb_drops_master: assert property (
      $rose(s_q.stat.arb_lost_flag) |-> !s_q.stat.master_active_flag)
      else $error("arbitration loss kept master flag");
   a_arb_read_clear: assert property (
      rd_done && !arb_loss |=> !s_q.stat.arb_lost_flag)
      else $error("arbitration flag not cleared by read");
   a_ext_on_eighth: assert property (
      eighth && (upper == `IBSF_EXT_LO || upper == `IBSF_EXT_HI) && !en_fall
         |=> s_q.stat.ext_code_flag)
      else $error("extension flag not set");
   a_ext_clears: assert property (
      (start_det || stop_det) && !eighth |=> !s_q.stat.ext_code_flag)
      else $error("extension flag not cleared");
   a_wrel_ends_trc: assert property (
      wait_release && s_q.stat.transmit_state_flag && !eighth && !start_det
         |=> !s_q.stat.transmit_state_flag && sda_oe_n_o)
      else $error("wait release kept transmit state");
   a_trc_hiz: assert property (
      !s_q.stat.transmit_state_flag |-> sda_oe_n_o)
      else $error("data line driven in receive state");

endmodule : ibsf_status

/* ibsf_peer.sv */
`timescale 1ns/100ps
// ==========
// open-drain peer on the serial link
module ibsf_peer (
   // design pin enables
   input wire logic scl_oe_n_i,
   input wire logic sda_oe_n_i,
   // resolved bus lines
   output logic scl_o,
   output logic sda_o
);
   logic scl_low;
   logic sda_low;
   // pull-ups: a line is low if any party pulls it
   assign scl_o = scl_oe_n_i & ~scl_low;
   assign sda_o = sda_oe_n_i & ~sda_low;
   // idle bus, clock stands still between frames
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // start: data falls while clock high
   task start_cond;
      sda_low = 1'b1;
      #40 scl_low = 1'b1;
   endtask : start_cond
   // one bit over an 80 ns clock, data moves while clock low
   task send_bit(input logic b);
      sda_low = ~b;
      #20 scl_low = 1'b0;
      #40 scl_low = 1'b1;
      #20;
   endtask : send_bit
   // stop: data rises while clock high
   task stop_cond;
      sda_low = 1'b1;
      #20 scl_low = 1'b0;
      #40 sda_low = 1'b0;
      #40;
   endtask : stop_cond
endmodule : ibsf_peer

/* ibsf_status_tb.sv */
`timescale 1ns/100ps
`include "ibsf_map.svh"
// ==========
// bench for the status flag block
module ibsf_status_tb;
   localparam logic [15:0] st_addr = `IBSF_STATUS_OFF;
   localparam logic [15:0] ct_addr = `IBSF_CONTROL_OFF;
   logic clk;
   logic rst_n;
   ibsf_pkg::ibsf_cpu_req_s req;
   logic [7:0] rdata;
   logic wt;
   logic [6:0] own;
   logic latch;
   logic en;
   logic st;
   logic sp;
   logic scl;
   logic sda;
   logic scl_oe_n;
   logic sda_oe_n;
   logic [7:0] d;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;

   ibsf_status ibsf_status_i (.sys_clk_i(clk), .rst_n_i(rst_n), .cpu_req_i(req),
      .cpu_rdata_o(rdata), .cpu_wait_o(wt), .own_slave_addr_i(own),
      .shift_out_latch_i(latch), .controller_enable_o(en), .start_request_o(st),
      .stop_request_o(sp), .scl_i(scl), .scl_o(), .scl_oe_n_o(scl_oe_n), .sda_i(sda),
      .sda_o(), .sda_oe_n_o(sda_oe_n));
   ibsf_peer ibsf_peer_i (.scl_oe_n_i(scl_oe_n), .sda_oe_n_i(sda_oe_n), .scl_o(scl),
      .sda_o(sda));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // compare and count
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // closing report
   task give_verdict;
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   // two-cycle reset
   task do_reset;
      @(posedge clk);
      #1 rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
   endtask : do_reset

   // one-cycle register write
   task wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      #1 req = '{addr: a, rd: 1'b0, wr: 1'b1, wdata: v};
      @(posedge clk);
      #1 req.wr = 1'b0;
   endtask : wr

   // read held through the wait cycle
   task rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge clk);
      #1 req = '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      #1 chk("wait", {7'h00, wt}, {7'h00, a == st_addr});
      @(posedge clk);
      #1 v = rdata;
      @(posedge clk);
      #1 req.rd = 1'b0;
   endtask : rd

   task t_regs;
      rd(st_addr, d);
      chk("status", d, 8'h00);
      wr(st_addr, 8'hff);
      rd(st_addr, d);
      chk("status", d, 8'h00);
      rd(16'h0000, d);
      chk("unmapped", d, 8'h00);
      wr(ct_addr, 8'h80);
      chk("enable", {7'h00, en}, 8'h01);
      $display("test regs done");
   endtask : t_regs

   task t_master;
      latch = 1'b0; // own bits are zeros, so the stop is no loss
      wr(ct_addr, 8'h82);
      ibsf_peer_i.start_cond();
      repeat (6) @(posedge clk);
      rd(st_addr, d);
      chk("status", d, 8'h8a);
      wr(ct_addr, 8'h81);
      chk("stop pulse", {7'h00, sp}, 8'h01);
      @(posedge clk);
      #1 chk("stop pulse", {7'h00, sp}, 8'h00);
      rd(ct_addr, d);
      chk("control", d, 8'h80);
      ibsf_peer_i.stop_cond();
      repeat (6) @(posedge clk);
      rd(st_addr, d);
      chk("status", d & 8'hf0, 8'h00);
      $display("test master done");
   endtask : t_master

   task t_exit;
      wr(ct_addr, 8'h82);
      ibsf_peer_i.start_cond();
      repeat (6) @(posedge clk);
      wr(ct_addr, 8'hc0);
      rd(st_addr, d);
      chk("master", d & 8'h80, 8'h00);
      ibsf_peer_i.stop_cond();
      $display("test exit done");
   endtask : t_exit

   task t_arb;
      latch = 1'b1; // released one against a peer zero
      wr(ct_addr, 8'h82);
      ibsf_peer_i.start_cond();
      ibsf_peer_i.send_bit(1'b0);
      repeat (6) @(posedge clk);
      rd(st_addr, d);
      chk("arb", d & 8'hc0, 8'h40);
      rd(st_addr, d);
      chk("arb", d & 8'hc0, 8'h00);
      ibsf_peer_i.stop_cond();
      $display("test arb done");
   endtask : t_arb

   task t_slave;
      logic [7:0] addr_byte;
      addr_byte = 8'hf1;
      latch = 1'b0;
      own = 7'h78;
      ibsf_peer_i.start_cond();
      for (int i = 7; i >= 0; i--) begin
         ibsf_peer_i.send_bit(addr_byte[i]);
      end
      ibsf_peer_i.send_bit(1'b0);
      repeat (6) @(posedge clk);
      #1 chk("clock hold", {7'h00, scl_oe_n}, 8'h00);
      chk("data drive", {7'h00, sda_oe_n}, 8'h00);
      wr(ct_addr, 8'h82);
      chk("start req", {7'h00, st}, 8'h01);
      rd(ct_addr, d);
      chk("control", d, 8'h82);
      rd(st_addr, d);
      chk("status", d & 8'hfc, 8'h3c);
      wr(ct_addr, 8'ha0);
      repeat (2) @(posedge clk);
      #1 chk("clock hold", {7'h00, scl_oe_n}, 8'h01);
      chk("data drive", {7'h00, sda_oe_n}, 8'h01);
      rd(st_addr, d);
      chk("status", d & 8'hf8, 8'h30);
      ibsf_peer_i.stop_cond();
      repeat (6) @(posedge clk);
      rd(st_addr, d);
      chk("status", d & 8'hf1, 8'h01);
      $display("test slave done");
   endtask : t_slave

   // main sequence
   initial begin
      req = '0;
      rst_n = 1'b0;
      own = 7'h00;
      latch = 1'b1;
      do_reset();
      t_regs();
      t_master();
      t_exit();
      t_arb();
      t_slave();
      do_reset();
      rd(st_addr, d);
      chk("status", d, 8'h00);
      give_verdict();
   end

   // cycle ceiling against hangs
   always @(posedge clk) begin
      cyc++;
      if (cyc > 5000) begin
         n_errors++;
         give_verdict();
      end
   end
endmodule : ibsf_status_tb
